// ### core/itr_gain_env.sv
// per-input level tracker and closing gain ramp
// assumes one step pulse per audio sample from the router core
`include "itr_map.svh"
module itr_gain_env #(
  parameter int SAMPLE_HZ = 48000
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // per-sample control
  input  wire logic        step,
  input  wire logic [23:0] level,
  input  wire logic        open_now,
  // results
  output logic             active,
  output logic [23:0]      gain
);
  import itr_pkg::*;

  localparam int          CLOSE_SAMPLES = `ITR_CLOSE_MS * SAMPLE_HZ / 1000;
  localparam logic [23:0] STEP = 24'((`ITR_GAIN_OPEN - `ITR_GAIN_CLOSED) / CLOSE_SAMPLES);

  typedef struct packed {
    logic [23:0] avg;
    logic [23:0] gain;
  } itr_env_s;

  itr_env_s           s_q;
  itr_env_s           s_d;
  logic signed [24:0] diff;

  // threshold rides above the running average
  assign active = {2'b00, level} > (({2'b00, s_q.avg} << `ITR_THR_SHIFT) + `ITR_LVL_FLOOR); // R10
  assign gain   = s_q.gain;

  always_comb begin
    s_d  = s_q;
    diff = $signed({1'b0, level}) - $signed({1'b0, s_q.avg});
    if (step) begin
      s_d.avg = 24'($signed({1'b0, s_q.avg}) + (diff >>> `ITR_AVG_SHIFT)); // R10
      if (open_now) begin
        s_d.gain = `ITR_GAIN_OPEN; // R07
      end else if (s_q.gain > `ITR_GAIN_CLOSED + STEP) begin
        s_d.gain = s_q.gain - STEP; // R07
      end else begin
        s_d.gain = `ITR_GAIN_CLOSED; // R09
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q.avg  <= '0;
      s_q.gain <= `ITR_GAIN_OPEN;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_gain_floor: assert property (@(posedge aclk) disable iff (!aresetn) // R09
    s_q.gain >= `ITR_GAIN_CLOSED) else $error("gain fell below closed level");
  a_open_jump: assert property (@(posedge aclk) disable iff (!aresetn) // R07
    step && open_now |=> s_q.gain == `ITR_GAIN_OPEN) else $error("open did not restore gain");
  a_ramp_slope: assert property (@(posedge aclk) disable iff (!aresetn) // R07
    step && !open_now |=> $past(s_q.gain) - s_q.gain <= STEP)
    else $error("closing ramp too steep");

endmodule : itr_gain_env

// ### core/itr_router.sv
// input-to-track routing matrix with automatic mixer, AXI4-Lite registers
// assumes samples arrive on aclk with a one-cycle smp_valid strobe,
// at most one strobe every three cycles
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`include "itr_map.svh"

// Overview of operation
// R01: any input routes to any tracks
// R02: tap choice held per track
// R03: pre-fade tracks take post-trim signal
// R04: only armed tracks are written
// R05: fixed presets, last three custom maps
// R06: automix touches post-fade signals only
// R07: open at once, close ramp 500 ms
// R08: no limit on open inputs
// R09: closed inputs sit 20 dB down
// R10: threshold follows running level average
// R11: minus 3 dB per open doubling
// R12: last active input stays open
// R13: only loudest copy of audio opens
// R14: automix only in two modes
// R15: manual inputs held open full gain
// R16: pair-only mode touches L and R
// R17: all-tracks mode touches every post-fade
// R18: bright when open, off when closed
// R19: manual unattenuated, counted, dim indicator
// R20: automix off above 48.048 kHz
// R21: per-sample gain, factors multiplied
module itr_router #(
  parameter int SAMPLE_HZ = 48000
) (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // register bus
  input  wire itr_pkg::itr_axi_req_s       axi_req,
  output itr_pkg::itr_axi_rsp_s            axi_rsp,
  // audio inputs
  input  wire logic                        smp_valid,
  input  wire itr_pkg::itr_smp_t [7:0]     trim_smp,
  input  wire itr_pkg::itr_smp_t [7:0]     fade_smp,
  // recording tracks
  output logic                             track_valid,
  output itr_pkg::itr_smp_t [11:0]         track_smp,
  output logic [11:0]                      track_write,
  // input activity indicators
  output itr_pkg::itr_led_e [7:0]          led_state
);
  import itr_pkg::*;

  // a literal cannot be part-selected, so the table is held here
  localparam bit [$bits(`ITR_NOM_TABLE)-1:0] NOM_TABLE = `ITR_NOM_TABLE;

  typedef struct packed {
    itr_axi_rsp_s               rsp;
    logic                       aw_held;
    logic [7:0]                 awaddr;
    logic                       w_held;
    logic [31:0]                wdata;
    logic [3:0]                 wstrb;
    itr_mode_e                  automix_mode_select;
    logic [2:0]                 preset;
    logic [17:0]                rate;
    logic [7:0]                 manual;
    logic [11:0]                prefade;
    logic [11:0]                arm;
    logic [2:0][7:0][11:0]      custom;
    itr_smp_t [7:0]             trim_c;
    itr_smp_t [7:0]             fade_c;
    logic                       p1;
    logic [7:0]                 open;
    logic [2:0]                 last;
    logic [3:0]                 count;
    logic                       track_valid;
    itr_smp_t [11:0]            track_smp;
    logic [11:0]                track_write;
    itr_led_e [7:0]             led;
  } itr_state_s;

  itr_state_s                   s_q;
  itr_state_s                   s_d;
  logic                         am_on;
  logic                         mode_all;
  logic [7:0][23:0]             lvl;
  logic [7:0]                   act;
  logic [7:0][23:0]             g_env;
  logic [7:0]                   bleed;
  logic [7:0]                   opn;
  logic [23:0]                  mx;
  logic [2:0]                   mi;
  logic [11:0]                  route [8];
  logic [`ITR_NOM_W-1:0]        nom;
  itr_smp_t [7:0]               att;
  itr_smp_t [11:0]              mix;
  logic [11:0]                  has_src;
  logic [31:0]                  rd_data;
  logic                         rd_err;
  logic [4:0]                   cus_idx;

  // ---------------------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------------------
  assign mode_all = s_q.automix_mode_select == automix_all_postfade_tracks;
  assign am_on    = (s_q.automix_mode_select == automix_main_pair_only || mode_all) // R14
                    && s_q.rate <= `ITR_RATE_LIMIT; // R20

  // byte-lane merge into an existing word
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // ---------------------------------------------------------------------------
  // effective routing map
  // ---------------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      case (s_q.preset) // R05
        3'd0: route[i] = (i[0] ? `ITR_TRK_R_MASK : `ITR_TRK_L_MASK) | (`ITR_TRK_ISO_MASK << i);
        3'd1: route[i] = i[0] ? `ITR_TRK_R_MASK : `ITR_TRK_L_MASK;
        3'd2: route[i] = `ITR_TRK_ISO_MASK << i;
        3'd3: route[i] = `ITR_TRK_L_MASK | `ITR_TRK_R_MASK;
        default: route[i] = s_q.custom[2'(s_q.preset - `ITR_FIRST_CUSTOM)][i]; // R01
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // per-input level engines
  // ---------------------------------------------------------------------------
  for (genvar gi = 0; gi < 8; gi++) begin : g_in
    assign lvl[gi] = fade_smp[gi][23] ? 24'(-fade_smp[gi]) : 24'(fade_smp[gi]);
    // active inputs more than four times quieter than the loudest are treated as pickup of it
    assign bleed[gi] = act[gi] && (({2'b00, lvl[gi]} << `ITR_BLEED_SHIFT) < {2'b00, mx}); // R13
    // automix attenuation on the post-fade path, counted gain times ramp
    always_comb begin
      logic [39:0]        gp;
      logic signed [48:0] sp;
      gp       = g_env[gi] * nom; // R21
      sp       = s_q.fade_c[gi] * $signed({1'b0, gp[39:16]}); // R11
      att[gi]  = sp[47:24];
    end
    itr_gain_env #(
      .SAMPLE_HZ (SAMPLE_HZ)
    ) u_env (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .step     (smp_valid),
      .level    (lvl[gi]),
      .open_now (opn[gi] | ~am_on),
      .active   (act[gi]),
      .gain     (g_env[gi])
    );
  end

  // loudest active input and open set
  always_comb begin
    mx  = '0;
    mi  = s_q.last;
    for (int i = 0; i < 8; i++) begin
      if (act[i] && lvl[i] > mx) begin
        mx = lvl[i];
        mi = 3'(i);
      end
    end
    opn = (act & ~bleed) | s_q.manual; // R08 R15 R19
    if (opn == '0) begin
      opn[s_q.last] = 1'b1; // R12
    end
  end

  assign nom = NOM_TABLE[s_q.count*`ITR_NOM_W +: `ITR_NOM_W]; // R11

  // ---------------------------------------------------------------------------
  // track mixing
  // ---------------------------------------------------------------------------
  for (genvar gt = 0; gt < 12; gt++) begin : g_trk
    always_comb begin
      logic signed [26:0] acc;
      logic               hit;
      itr_smp_t           src;
      acc = '0;
      hit = 1'b0;
      src = '0;
      for (int i = 0; i < 8; i++) begin
        if (s_q.prefade[gt]) begin
          src = s_q.trim_c[i]; // R02 R03 R06
        end else if (am_on && !s_q.manual[i] && (mode_all || gt < `ITR_NUM_MAIN)) begin
          src = att[i]; // R16 R17
        end else begin
          src = s_q.fade_c[i]; // R19
        end
        if (route[i][gt]) begin
          acc = acc + 27'(src);
          hit = 1'b1;
        end
      end
      has_src[gt] = hit;
      if (acc > 27'sh07fffff) begin
        mix[gt] = 24'sh7fffff;
      end else if (acc < -27'sh0800000) begin
        mix[gt] = -24'sh800000;
      end else begin
        mix[gt] = acc[23:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // register read decode
  // ---------------------------------------------------------------------------
  assign cus_idx = 5'((axi_req.araddr - `ITR_CUSTOM_BASE) >> `ITR_WORD_SHIFT);
  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    if (axi_req.araddr == `ITR_ADDR_CTRL) begin
      rd_data[`ITR_CTRL_MODE]   = s_q.automix_mode_select;
      rd_data[`ITR_CTRL_PRESET] = s_q.preset;
    end else if (axi_req.araddr == `ITR_ADDR_RATE) begin
      rd_data[`ITR_RATE_FLD] = s_q.rate;
    end else if (axi_req.araddr == `ITR_ADDR_MANUAL) begin
      rd_data[`ITR_IN_FLD] = s_q.manual;
    end else if (axi_req.araddr == `ITR_ADDR_PREFADE) begin
      rd_data[`ITR_TRK_FLD] = s_q.prefade;
    end else if (axi_req.araddr == `ITR_ADDR_ARM) begin
      rd_data[`ITR_TRK_FLD] = s_q.arm;
    end else if (axi_req.araddr == `ITR_ADDR_STATUS) begin
      rd_data[`ITR_ST_OPEN]   = s_q.open;
      rd_data[`ITR_ST_COUNT]  = s_q.count;
      rd_data[`ITR_ST_ACTIVE] = am_on;
    end else if (axi_req.araddr == `ITR_ADDR_LED) begin
      rd_data[`ITR_LED_FLD] = s_q.led;
    end else if (axi_req.araddr >= `ITR_CUSTOM_BASE && axi_req.araddr <= `ITR_CUSTOM_LAST
                 && axi_req.araddr[1:0] == 2'b00) begin
      rd_data[`ITR_TRK_FLD] = s_q.custom[cus_idx[`ITR_CUS_SLOT]][cus_idx[`ITR_CUS_INPUT]];
    end else begin
      rd_err = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [31:0] v;
    logic [4:0]  wi;
    s_d = s_q;
    v   = '0;
    wi  = 5'((s_q.awaddr - `ITR_CUSTOM_BASE) >> `ITR_WORD_SHIFT);
    // write channel: address and data taken in either order
    if (axi_req.awvalid && s_q.rsp.awready) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr  = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_q.rsp.wready) begin
      s_d.w_held = 1'b1;
      s_d.wdata  = axi_req.wdata;
      s_d.wstrb  = axi_req.wstrb;
    end
    if (s_q.rsp.bvalid && axi_req.bready) begin
      s_d.rsp.bvalid = 1'b0;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.rsp.bvalid) begin
      s_d.aw_held    = 1'b0;
      s_d.w_held     = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp  = `ITR_RESP_OKAY;
      if (s_q.awaddr == `ITR_ADDR_CTRL) begin
        v[`ITR_CTRL_MODE]   = s_q.automix_mode_select;
        v[`ITR_CTRL_PRESET] = s_q.preset;
        v = wmerge(v, s_q.wdata, s_q.wstrb);
        s_d.automix_mode_select = itr_mode_e'(v[`ITR_CTRL_MODE]);
        if (v[`ITR_CTRL_PRESET] < `ITR_NUM_PRESETS) begin
          s_d.preset = v[`ITR_CTRL_PRESET];
        end
      end else if (s_q.awaddr == `ITR_ADDR_RATE) begin
        v[`ITR_RATE_FLD] = s_q.rate;
        v = wmerge(v, s_q.wdata, s_q.wstrb);
        s_d.rate = v[`ITR_RATE_FLD];
      end else if (s_q.awaddr == `ITR_ADDR_MANUAL) begin
        v[`ITR_IN_FLD] = s_q.manual;
        v = wmerge(v, s_q.wdata, s_q.wstrb);
        s_d.manual = v[`ITR_IN_FLD];
      end else if (s_q.awaddr == `ITR_ADDR_PREFADE) begin
        v[`ITR_TRK_FLD] = s_q.prefade;
        v = wmerge(v, s_q.wdata, s_q.wstrb);
        s_d.prefade = v[`ITR_TRK_FLD]; // R02
      end else if (s_q.awaddr == `ITR_ADDR_ARM) begin
        v[`ITR_TRK_FLD] = s_q.arm;
        v = wmerge(v, s_q.wdata, s_q.wstrb);
        s_d.arm = v[`ITR_TRK_FLD];
      end else if (s_q.awaddr >= `ITR_CUSTOM_BASE && s_q.awaddr <= `ITR_CUSTOM_LAST
                   && s_q.awaddr[1:0] == 2'b00) begin
        v[`ITR_TRK_FLD] = s_q.custom[wi[`ITR_CUS_SLOT]][wi[`ITR_CUS_INPUT]];
        v = wmerge(v, s_q.wdata, s_q.wstrb);
        s_d.custom[wi[`ITR_CUS_SLOT]][wi[`ITR_CUS_INPUT]] = v[`ITR_TRK_FLD]; // R01 R05
      end else begin
        s_d.rsp.bresp = `ITR_RESP_SLVERR;
      end
    end
    s_d.rsp.awready = ~s_d.aw_held & ~s_d.rsp.bvalid;
    s_d.rsp.wready  = ~s_d.w_held & ~s_d.rsp.bvalid;
    // read channel
    if (s_q.rsp.rvalid && axi_req.rready) begin
      s_d.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s_q.rsp.arready) begin
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata  = rd_data;
      s_d.rsp.rresp  = rd_err ? `ITR_RESP_SLVERR : `ITR_RESP_OKAY;
    end
    s_d.rsp.arready = ~s_d.rsp.rvalid;
    // sample capture and open decision, once per sample
    s_d.p1 = smp_valid;
    if (smp_valid) begin
      s_d.trim_c = trim_smp;
      s_d.fade_c = fade_smp;
      s_d.open   = opn; // R21
      s_d.count  = 4'($countones(opn)); // R08
      if (act != '0) begin
        s_d.last = mi; // R12
      end
    end
    // track outputs and indicators
    s_d.track_valid = s_q.p1;
    if (s_q.p1) begin
      s_d.track_smp   = mix;
      s_d.track_write = s_q.arm & has_src; // R04
      for (int i = 0; i < 8; i++) begin
        if (!am_on) begin
          s_d.led[i] = led_meter;
        end else if (s_q.manual[i]) begin
          s_d.led[i] = led_dim; // R19
        end else begin
          s_d.led[i] = s_q.open[i] ? led_bright : led_closed; // R18
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q         <= '0;
      s_q.rate    <= `ITR_RATE_RST;
      s_q.prefade <= `ITR_PREFADE_RST;
      s_q.arm     <= `ITR_ARM_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign axi_rsp     = s_q.rsp;
  assign track_valid = s_q.track_valid;
  assign track_smp   = s_q.track_smp;
  assign track_write = s_q.track_write;
  assign led_state   = s_q.led;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  sequence s_sample_taken;
    smp_valid ##1 s_q.p1;
  endsequence

  sequence s_write_pair;
    s_q.aw_held && s_q.w_held && !s_q.rsp.bvalid;
  endsequence

  a_arm_gate: assert property (@(posedge aclk) disable iff (!aresetn) // R04
    s_q.p1 |=> (track_write & ~$past(s_q.arm)) == '0) else $error("unarmed track written");
  a_hold_last: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    s_sample_taken |-> s_q.open != '0) else $error("no input left open");
  a_manual_open: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    smp_valid |=> ($past(s_q.manual) & ~s_q.open) == '0) else $error("manual input closed");
  a_open_count: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    s_sample_taken |-> s_q.count == 4'($countones(s_q.open))) else $error("open count wrong");
  a_led_bright: assert property (@(posedge aclk) disable iff (!aresetn) // R18
    s_q.p1 && am_on && s_q.open[0] && !s_q.manual[0] |=> led_state[0] == led_bright)
    else $error("open input not shown bright");
  a_rate_off: assert property (@(posedge aclk) disable iff (!aresetn) // R20
    s_q.p1 && s_q.rate > `ITR_RATE_LIMIT |=> led_state == {8{led_meter}})
    else $error("automix active above rate limit");
  a_bus_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_pair |=> s_q.rsp.bvalid && !s_q.rsp.awready && !s_q.rsp.wready)
    else $error("write response missing");
  a_read_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.rsp.rvalid && !axi_req.rready |=> s_q.rsp.rvalid && $stable(s_q.rsp.rdata))
    else $error("read data dropped before taken");
  a_open_fast: assert property (@(posedge aclk) disable iff (!aresetn) // R07
    smp_valid && opn[0] |-> ##1 s_q.open[0]) else $error("input did not open on its sample");

endmodule : itr_router

// ### include/itr_map.svh
// named offsets, field ranges, reset values and gain constants of the router
// assumes inclusion by bare name from every file that needs it
`ifndef ITR_MAP_SVH
`define ITR_MAP_SVH

// ---------------------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------------------
`define ITR_ADDR_CTRL     8'h00
`define ITR_ADDR_RATE     8'h04
`define ITR_ADDR_MANUAL   8'h08
`define ITR_ADDR_PREFADE  8'h0c
`define ITR_ADDR_ARM      8'h10
`define ITR_ADDR_STATUS   8'h14
`define ITR_ADDR_LED      8'h18
`define ITR_CUSTOM_BASE   8'h40
`define ITR_CUSTOM_LAST   8'h9c

// ---------------------------------------------------------------------------
// field ranges
// ---------------------------------------------------------------------------
`define ITR_CTRL_MODE     1:0
`define ITR_CTRL_PRESET   6:4
`define ITR_RATE_FLD      17:0
`define ITR_IN_FLD        7:0
`define ITR_TRK_FLD       11:0
`define ITR_ST_OPEN       7:0
`define ITR_ST_COUNT      11:8
`define ITR_ST_ACTIVE     12
`define ITR_LED_FLD       15:0
`define ITR_CUS_SLOT      4:3
`define ITR_CUS_INPUT     2:0
`define ITR_WORD_SHIFT    2

// ---------------------------------------------------------------------------
// reset values and limits
// ---------------------------------------------------------------------------
`define ITR_RATE_RST      18'd48000
`define ITR_RATE_LIMIT    18'd48048
`define ITR_PREFADE_RST   12'hffc
`define ITR_ARM_RST       12'h3ff
`define ITR_NUM_PRESETS   3'd7
`define ITR_FIRST_CUSTOM  3'd4
`define ITR_NUM_MAIN      2
`define ITR_TRK_L_MASK    12'h001
`define ITR_TRK_R_MASK    12'h002
`define ITR_TRK_ISO_MASK  12'h004
`define ITR_RESP_OKAY     2'b00
`define ITR_RESP_SLVERR   2'b10

// ---------------------------------------------------------------------------
// gain engine
// ---------------------------------------------------------------------------
`define ITR_GAIN_OPEN     24'hffffff
`define ITR_GAIN_CLOSED   24'h19999a
`define ITR_CLOSE_MS      500
`define ITR_AVG_SHIFT     6
`define ITR_THR_SHIFT     2
`define ITR_BLEED_SHIFT   2
`define ITR_LVL_FLOOR     26'h0000100
`define ITR_NOM_W         16
`define ITR_NOM_TABLE     144'h5a82_60c2_6883_727d_8000_93cd_b505_ffff_ffff

`endif

// ### include/itr_pkg.sv
// types shared by the router core and its gain engine
// assumes nothing beyond a SystemVerilog compiler
package itr_pkg;

  typedef enum logic [1:0] {
    itr_mode_off                = 2'h0,
    automix_main_pair_only      = 2'h1,
    automix_all_postfade_tracks = 2'h2,
    itr_mode_rsvd               = 2'h3
  } itr_mode_e;

  typedef enum logic [1:0] {
    led_meter  = 2'h0,
    led_closed = 2'h1,
    led_dim    = 2'h2,
    led_bright = 2'h3
  } itr_led_e;

  typedef logic signed [23:0] itr_smp_t;
  typedef logic [11:0]        itr_route_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } itr_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } itr_axi_rsp_s;

endpackage : itr_pkg

// ### verif/input_track_router_automixer_tb.sv
// router bench: register tasks and sample checks
// assumes the router core and the source model
`include "itr_map.svh"
module input_track_router_automixer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import itr_pkg::*;
  logic            aclk = 1'b0;
  logic            aresetn = 1'b0;
  itr_axi_req_s    req = '0;
  itr_axi_rsp_s    rsp;
  logic            smp_valid;
  logic            track_valid;
  itr_smp_t [7:0]  trim_lvl = '0;
  itr_smp_t [7:0]  fade_lvl = '0;
  itr_smp_t [7:0]  trim_smp;
  itr_smp_t [7:0]  fade_smp;
  itr_smp_t [11:0] track_smp;
  logic [11:0]     track_write;
  itr_led_e [7:0]  led_state;
  int              err_total = 0;
  int              checks = 0;
  always #2 aclk = ~aclk;
  itr_src_model src (.aclk(aclk), .aresetn(aresetn), .trim_lvl(trim_lvl),
    .fade_lvl(fade_lvl), .smp_valid(smp_valid), .trim_smp(trim_smp), .fade_smp(fade_smp));
  itr_router #(.SAMPLE_HZ(480)) uut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .smp_valid(smp_valid), .trim_smp(trim_smp), .fade_smp(fade_smp),
    .track_valid(track_valid), .track_smp(track_smp), .track_write(track_write),
    .led_state(led_state));
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
    req <= '{a, 1'b1, d, 4'hf, 1'b1, 1'b1, 8'h0, 1'b0, 1'b0};
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
    chk(32'(rsp.bresp), 32'(rs));
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] rs);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
    chk(rsp.rdata & m, e);
    chk(32'(rsp.rresp), 32'(rs));
    @(posedge aclk);
  endtask : rd
  // waits n track strobes; outputs then hold
  task automatic smp(input int n);
    repeat (n) begin
      do @(posedge aclk); while (track_valid !== 1'b1);
    end
  endtask : smp
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    #20000;
    err_total++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`ITR_ADDR_RATE, 32'h3ffff, 32'd48000, `ITR_RESP_OKAY);
    rd(`ITR_ADDR_PREFADE, 32'hfff, 32'hffc, `ITR_RESP_OKAY);
    rd(`ITR_ADDR_ARM, 32'hfff, 32'h3ff, `ITR_RESP_OKAY);
    rd(8'h3c, 32'hffffffff, 32'h0, `ITR_RESP_SLVERR);
    wr(`ITR_ADDR_STATUS, 32'h0, `ITR_RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      trim_lvl[i] <= 24'(i + 1) << 8;
      fade_lvl[i] <= 24'(i + 1) << 12;
    end
    smp(2);
    chk(track_smp[0], 32'h10000);
    chk(track_smp[1], 32'h14000);
    chk(track_smp[2], 32'h100);
    chk(track_smp[9], 32'h800);
    chk(32'(track_write), 32'h3ff);
    wr(`ITR_ADDR_ARM, 32'h1, `ITR_RESP_OKAY);
    smp(2);
    chk(32'(track_write), 32'h1);
    wr(`ITR_ADDR_PREFADE, 32'h0, `ITR_RESP_OKAY);
    wr(`ITR_ADDR_ARM, 32'hfff, `ITR_RESP_OKAY);
    wr(`ITR_ADDR_CTRL, 32'h40, `ITR_RESP_OKAY);
    wr(8'h4c, 32'h800, `ITR_RESP_OKAY);
    smp(2);
    chk(32'(track_write), 32'h800);
    chk(track_smp[11], 32'h4000);
    wr(`ITR_ADDR_CTRL, 32'h30, `ITR_RESP_OKAY);
    fade_lvl <= {8{24'h400000}};
    smp(2);
    chk(track_smp[0], 32'h7fffff);
    wr(`ITR_ADDR_MANUAL, 32'hff, `ITR_RESP_OKAY);
    wr(`ITR_ADDR_CTRL, 32'h31, `ITR_RESP_OKAY);
    smp(2);
    chk(track_smp[1], 32'h7fffff);
    chk(32'(led_state), 32'haaaa);
    rd(`ITR_ADDR_STATUS, 32'h1fff, 32'h18ff, `ITR_RESP_OKAY);
    wr(`ITR_ADDR_RATE, 32'd48049, `ITR_RESP_OKAY);
    smp(2);
    chk(32'(led_state), 32'h0);
    rd(`ITR_ADDR_STATUS, 32'h1000, 32'h0, `ITR_RESP_OKAY);
    wr(`ITR_ADDR_RATE, 32'd48000, `ITR_RESP_OKAY);
    wr(`ITR_ADDR_CTRL, 32'h33, `ITR_RESP_OKAY);
    rd(`ITR_ADDR_STATUS, 32'h1000, 32'h0, `ITR_RESP_OKAY);
    wr(`ITR_ADDR_CTRL, 32'h31, `ITR_RESP_OKAY);
    wr(`ITR_ADDR_MANUAL, 32'h0, `ITR_RESP_OKAY);
    fade_lvl <= '0;
    smp(80);
    fade_lvl[5] <= 24'h7fffff;
    smp(2);
    chk(32'(led_state), 32'h5d55);
    fade_lvl[5] <= 24'h0;
    smp(2);
    chk(32'(led_state), 32'h5d55);
    wr(`ITR_ADDR_CTRL, 32'h01, `ITR_RESP_OKAY);
    fade_lvl[0] <= 24'h7fffff;
    smp(2);
    chk(track_smp[2], 32'h7fffff);
    chk(track_smp[0], 32'h7fff7e);
    wr(`ITR_ADDR_CTRL, 32'h02, `ITR_RESP_OKAY);
    smp(2);
    chk(track_smp[2], 32'h7fff7e);
    wr(`ITR_ADDR_PREFADE, 32'h4, `ITR_RESP_OKAY);
    smp(2);
    chk(track_smp[2], 32'h100);
    report_and_stop;
  end
endmodule : input_track_router_automixer_tb

// ### verif/itr_src_model.sv
// audio source model: one sample strobe every four clocks
// assumes the bench sets the levels that each strobe carries
module itr_src_model (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // levels from the bench
  input  wire itr_pkg::itr_smp_t [7:0] trim_lvl,
  input  wire itr_pkg::itr_smp_t [7:0] fade_lvl,
  // samples to the router
  output logic                         smp_valid,
  output itr_pkg::itr_smp_t [7:0]      trim_smp,
  output itr_pkg::itr_smp_t [7:0]      fade_smp
);
  timeunit 1ns;
  timeprecision 100ps;
  import itr_pkg::*;
  logic [1:0] cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_q <= 2'h0;
    else cnt_q <= cnt_q + 2'h1;
  end
  // values only valid at the strobe, scrambled in between
  always_comb begin
    smp_valid = aresetn && (cnt_q == 2'h3);
    trim_smp  = smp_valid ? trim_lvl : ~trim_lvl;
    fade_smp  = smp_valid ? fade_lvl : ~fade_lvl;
  end
endmodule : itr_src_model
